// File: design/cad_decoder.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] Inherent instructions are one byte; the opcode says everything.
// [RULE2] Immediate instructions are opcode plus one operand value byte.
// [RULE3] Short direct fetches one address byte; operand lies in 00..FF.
// [RULE4] Long direct fetches a two-byte address covering 64 Kbyte.
// [RULE5] Indexed address is unsigned index register plus instruction offset.
// [RULE6] No-offset indexed has no extra byte; address is the index value.
// [RULE7] Short indexed fetches a one-byte offset; sum reaches 00..1FE.
// [RULE8] Long indexed fetches a two-byte offset covering 64 Kbyte.
// [RULE9] Indirect reads a pointer at the byte address after the opcode.
// [RULE10] Short indirect pointer is one byte; long indirect pointer is a word.
// [RULE11] Indirect indexed address is index plus pointer read from memory.
// [RULE12] Short indirect indexed uses byte pointer; long form uses word pointer.
// [RULE13] Relative instructions add an 8-bit signed offset to the program counter.
// [RULE14] Relative direct offset follows opcode; relative indirect offset read from memory.
// [RULE15] Only load, compare, logical, add/sub, bit compare allow long forms.
// [RULE16] Total instruction length runs from one to four bytes.
// [RULE17] After prebyte and opcode, zero to two addressing bytes follow.
// [RULE18] A prebyte directly precedes the opcode and changes its meaning.
// [RULE19] Prebyte 90 moves an X-based instruction onto the second index register.
// [RULE20] Prebyte 92 turns direct forms indirect and X indexed into indirect indexed.
// [RULE21] Prebyte 91 turns X indirect indexed into Y indirect indexed.
// [RULE22] Relative base is the address of the instruction after the jump.
// [RULE23] A prebyte with an opcode it cannot modify is flagged illegal.
module cad_decoder
    import cad_pkg::*;
(
    input  wire logic        sys_clk_in,    // Core clock
    input  wire logic        rst_b_in,      // Synchronous reset, active low
    input  wire logic        start_in,      // Decode one instruction at pc_in
    input  wire logic [15:0] pc_in,         // Address of first instruction byte
    input  wire logic [7:0]  x_in,          // First index register
    input  wire logic [7:0]  y_in,          // Second index register
    input  wire logic [7:0]  mem_rdata_in,  // Read data, valid with ack
    input  wire logic        mem_ack_in,    // Read completes this cycle
    output logic      [15:0] mem_addr_out,  // Read address
    output logic             mem_rd_out,    // Read request, held until ack
    output logic             busy_out,      // Decode in progress
    output logic             done_out,      // One-cycle result strobe
    output cad_res_s         res_out        // Decoded instruction
);

    cad_st_s st_ff;
    cad_st_s nxt_st;
    cad_dec_s dec;

    function automatic logic is_prebyte(input logic [7:0] b);
        return (b == SECOND_INDEX_PREBYTE) || (b == SECOND_INDEX_INDIRECT_PREBYTE) ||
               (b == INDIRECT_MODE_PREBYTE);
    endfunction : is_prebyte

    function automatic logic is_indexed(input cad_mode_e m);
        return (m == AM_IDX0) || (m == AM_IDX_S) || (m == AM_IDX_L) ||
               (m == AM_IIDX_S) || (m == AM_IIDX_L);
    endfunction : is_indexed

    function automatic logic needs_pointer(input cad_mode_e m);
        return (m == AM_IND_S) || (m == AM_IND_L) || (m == AM_IIDX_S) ||
               (m == AM_IIDX_L) || (m == AM_REL_I);
    endfunction : needs_pointer

    function automatic cad_dec_s cad_decode(input logic [7:0] pre, input logic [7:0] opc);
        cad_dec_s d;
        logic     long_ok;
        d = '{AM_INH, 1'b0, 2'd0, 1'b0, 1'b0, 1'b0};
        long_ok = (opc[3:0] <= OP_LAST_LONG);
        case (opc[7:4])
            GRP_INH: d.mode = AM_INH;  // [RULE1]
            GRP_IMM: begin
                d.mode  = AM_IMM;
                d.nargs = 2'd1;  // [RULE2]
            end
            GRP_DIRS: begin
                d.mode  = AM_DIR_S;
                d.btj   = (opc[3:0] == OP_BIT_JUMP);
                d.nargs = d.btj ? 2'd2 : 2'd1;  // [RULE3]
            end
            GRP_DIRL: begin
                d.mode    = AM_DIR_L;
                d.nargs   = 2'd2;  // [RULE4]
                d.illegal = !long_ok;  // [RULE15]
            end
            GRP_IDX0: d.mode = AM_IDX0;  // [RULE6]
            GRP_IDXS: begin
                d.mode  = AM_IDX_S;
                d.nargs = 2'd1;  // [RULE7]
            end
            GRP_IDXL: begin
                d.mode    = AM_IDX_L;
                d.nargs   = 2'd2;  // [RULE8]
                d.illegal = !long_ok;  // [RULE15]
            end
            GRP_REL: begin
                d.mode  = AM_REL_D;
                d.nargs = 2'd1;  // [RULE14]
            end
            default: d.illegal = 1'b1;
        endcase
        case (pre)  // [RULE18]
            SECOND_INDEX_PREBYTE: begin
                d.iy = 1'b1;  // [RULE19]
                if (d.mode == AM_REL_D) begin
                    d.illegal = 1'b1;  // [RULE23]
                end
            end
            INDIRECT_MODE_PREBYTE: begin
                d.nargs = d.btj ? 2'd2 : 2'd1;  // [RULE9]
                case (d.mode)  // [RULE20]
                    AM_DIR_S: d.mode = AM_IND_S;
                    AM_DIR_L: begin
                        d.mode = AM_IND_L;
                        d.ptrw = 1'b1;  // [RULE10]
                    end
                    AM_IDX_S: d.mode = AM_IIDX_S;
                    AM_IDX_L: begin
                        d.mode = AM_IIDX_L;
                        d.ptrw = 1'b1;  // [RULE12]
                    end
                    AM_REL_D: d.mode = AM_REL_I;
                    default:  d.illegal = 1'b1;  // [RULE23]
                endcase
            end
            SECOND_INDEX_INDIRECT_PREBYTE: begin
                d.iy    = 1'b1;  // [RULE21]
                d.nargs = 2'd1;
                case (d.mode)
                    AM_IDX_S: d.mode = AM_IIDX_S;
                    AM_IDX_L: begin
                        d.mode = AM_IIDX_L;
                        d.ptrw = 1'b1;
                    end
                    default:  d.illegal = 1'b1;                              // [RULE23]
                endcase
            end
            default: d.iy = 1'b0;
        endcase
        return d;
    endfunction : cad_decode

    // Effective address and next/target program counter for a finished decode
    function automatic cad_res_s cad_finish(input cad_res_s r, input logic [15:0] val,
                                            input logic [7:0] idx, input logic [15:0] pc,
                                            input logic [7:0] off, input logic rel);
        cad_res_s o;
        o    = r;
        o.ea = val + (is_indexed(r.mode) ? {8'h00, idx} : 16'h0000);    // [RULE5] [RULE11]
        // Base is already past the last instruction byte
        o.target = rel ? pc + {{8{off[7]}}, off} : pc;                   // [RULE13] [RULE22]
        return o;
    endfunction : cad_finish

    assign dec = cad_decode(st_ff.res.prebyte, mem_rdata_in);

    always_comb begin
        logic [7:0]  a0;
        logic [7:0]  idx;
        logic [15:0] val;
        logic        rel;
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        a0  = (st_ff.argi == 2'd0) ? mem_rdata_in : st_ff.arg0;
        idx = st_ff.res.iy ? st_ff.y : st_ff.x;
        val = 16'h0000;
        rel = (st_ff.res.mode == AM_REL_D) || (st_ff.res.mode == AM_REL_I) || st_ff.btj;
        case (st_ff.fsm)
            ST_IDLE: begin
                if (start_in) begin
                    nxt_st.pc       = pc_in;
                    nxt_st.x        = x_in;
                    nxt_st.y        = y_in;
                    nxt_st.res      = RES_RST;
                    nxt_st.mem_addr = pc_in;
                    nxt_st.mem_rd   = 1'b1;
                    nxt_st.fsm      = ST_OPC;
                end
            end
            ST_OPC: begin
                if (mem_ack_in) begin
                    nxt_st.pc      = st_ff.pc + 16'h0001;
                    nxt_st.res.len = st_ff.res.len + 3'h1;                   // [RULE16]
                    if (is_prebyte(mem_rdata_in) && st_ff.res.prebyte == NO_PREBYTE) begin
                        nxt_st.res.prebyte = mem_rdata_in;                   // [RULE18]
                        nxt_st.mem_addr    = st_ff.pc + 16'h0001;
                    end else begin
                        nxt_st.res.opcode = mem_rdata_in;
                        nxt_st.res.mode   = dec.mode;
                        nxt_st.res.iy     = dec.iy;
                        nxt_st.argc       = dec.nargs;                       // [RULE17]
                        nxt_st.argi       = 2'd0;
                        nxt_st.btj        = dec.btj;
                        nxt_st.ptrw       = dec.ptrw;
                        if (dec.illegal || is_prebyte(mem_rdata_in)) begin
                            // Undefined pair stops here rather than guessing a length
                            nxt_st.res.illegal = 1'b1;                       // [RULE23]
                            nxt_st.mem_rd      = 1'b0;
                            nxt_st.done        = 1'b1;
                            nxt_st.fsm         = ST_IDLE;
                        end else if (dec.nargs == 2'd0) begin
                            nxt_st.res = cad_finish(nxt_st.res, 16'h0000,
                                                    dec.iy ? st_ff.y : st_ff.x,
                                                    nxt_st.pc, 8'h00, 1'b0); // [RULE1] [RULE6]
                            nxt_st.mem_rd = 1'b0;
                            nxt_st.done   = 1'b1;
                            nxt_st.fsm    = ST_IDLE;
                        end else begin
                            nxt_st.mem_addr = st_ff.pc + 16'h0001;
                            nxt_st.fsm      = ST_ARG;
                        end
                    end
                end
            end
            ST_ARG: begin
                if (mem_ack_in) begin
                    nxt_st.pc      = st_ff.pc + 16'h0001;
                    nxt_st.res.len = st_ff.res.len + 3'h1;
                    nxt_st.argi    = st_ff.argi + 2'd1;
                    nxt_st.arg0    = a0;
                    nxt_st.arg1    = mem_rdata_in;
                    if (st_ff.argi + 2'd1 < st_ff.argc) begin
                        nxt_st.mem_addr = st_ff.pc + 16'h0001;
                    end else if (needs_pointer(st_ff.res.mode)) begin
                        nxt_st.mem_addr = {ZERO_PAGE, a0};                   // [RULE9]
                        nxt_st.argi     = 2'd0;
                        nxt_st.fsm      = ST_PTR;
                    end else begin
                        // Two bytes form a high-first word unless the second is a jump offset
                        val = (st_ff.argc == 2'd2 && !st_ff.btj) ? {a0, mem_rdata_in}
                                                                  : {ZERO_PAGE, a0}; // [RULE3] [RULE4]
                        nxt_st.res     = cad_finish(nxt_st.res, val, idx, nxt_st.pc,
                                                    st_ff.btj ? mem_rdata_in : a0, rel); // [RULE14]
                        nxt_st.res.imm = a0;                                 // [RULE2]
                        nxt_st.mem_rd  = 1'b0;
                        nxt_st.done    = 1'b1;
                        nxt_st.fsm     = ST_IDLE;
                    end
                end
            end
            ST_PTR: begin
                if (mem_ack_in) begin
                    if (st_ff.ptrw && st_ff.argi == 2'd0) begin
                        nxt_st.ptr_hi   = mem_rdata_in;                      // [RULE10]
                        nxt_st.argi     = 2'd1;
                        nxt_st.mem_addr = st_ff.mem_addr + 16'h0001;
                    end else begin
                        val = st_ff.ptrw ? {st_ff.ptr_hi, mem_rdata_in}
                                         : {ZERO_PAGE, mem_rdata_in};        // [RULE12]
                        if (st_ff.res.mode == AM_REL_I) begin
                            val = 16'h0000;
                        end
                        nxt_st.res    = cad_finish(st_ff.res, val, idx, st_ff.pc,
                                                   (st_ff.res.mode == AM_REL_I) ? mem_rdata_in
                                                                               : st_ff.arg1,
                                                   rel);                     // [RULE11] [RULE14]
                        nxt_st.mem_rd = 1'b0;
                        nxt_st.done   = 1'b1;
                        nxt_st.fsm    = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.fsm    = ST_IDLE;
                nxt_st.mem_rd = 1'b0;
            end
        endcase
        nxt_st.busy = (nxt_st.fsm != ST_IDLE);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            st_ff <= '{ST_IDLE, PC_RST, BYTE_RST, BYTE_RST, 2'd0, 2'd0, 1'b0, 1'b0, BYTE_RST,
                       BYTE_RST, BYTE_RST, ADDR_RST, 1'b0, 1'b0, 1'b0, RES_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mem_addr_out = st_ff.mem_addr;
    assign mem_rd_out   = st_ff.mem_rd;
    assign busy_out     = st_ff.busy;
    assign done_out     = st_ff.done;
    assign res_out      = st_ff.res;

endmodule : cad_decoder

// File: design/cad_pkg.sv
package cad_pkg;

    // Prebyte codes
    localparam logic [7:0] SECOND_INDEX_PREBYTE          = 8'h90;
    localparam logic [7:0] SECOND_INDEX_INDIRECT_PREBYTE = 8'h91;
    localparam logic [7:0] INDIRECT_MODE_PREBYTE         = 8'h92;
    localparam logic [7:0] NO_PREBYTE                    = 8'h00;

    // Opcode high nibble selects the addressing group
    localparam logic [3:0] GRP_INH  = 4'h0;
    localparam logic [3:0] GRP_IMM  = 4'h1;
    localparam logic [3:0] GRP_DIRS = 4'h2;
    localparam logic [3:0] GRP_DIRL = 4'h3;
    localparam logic [3:0] GRP_IDX0 = 4'h4;
    localparam logic [3:0] GRP_IDXS = 4'h5;
    localparam logic [3:0] GRP_IDXL = 4'h6;
    localparam logic [3:0] GRP_REL  = 4'h7;

    // Opcode low nibble selects the operation class; 0..4 may use long forms
    localparam logic [3:0] OP_LAST_LONG = 4'h4;
    localparam logic [3:0] OP_BIT_JUMP  = 4'hb;

    localparam logic [7:0]  ZERO_PAGE = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [15:0] ADDR_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [2:0]  LEN_RST   = 3'h0;

    typedef enum logic [3:0] {
        AM_INH    = 4'h0,
        AM_IMM    = 4'h1,
        AM_DIR_S  = 4'h2,
        AM_DIR_L  = 4'h3,
        AM_IDX0   = 4'h4,
        AM_IDX_S  = 4'h5,
        AM_IDX_L  = 4'h6,
        AM_IND_S  = 4'h7,
        AM_IND_L  = 4'h8,
        AM_IIDX_S = 4'h9,
        AM_IIDX_L = 4'ha,
        AM_REL_D  = 4'hb,
        AM_REL_I  = 4'hc
    } cad_mode_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_OPC  = 4'h2,
        ST_ARG  = 4'h4,
        ST_PTR  = 4'h8
    } cad_fsm_e;

    typedef struct packed {
        cad_mode_e  mode;
        logic       iy;
        logic [1:0] nargs;
        logic       ptrw;
        logic       btj;
        logic       illegal;
    } cad_dec_s;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  prebyte;
        cad_mode_e   mode;
        logic        iy;
        logic [2:0]  len;
        logic [7:0]  imm;
        logic [15:0] ea;
        logic [15:0] target;
        logic        illegal;
    } cad_res_s;

    localparam cad_res_s RES_RST = '{BYTE_RST, NO_PREBYTE, AM_INH, 1'b0, LEN_RST,
                                     BYTE_RST, ADDR_RST, PC_RST, 1'b0};

    typedef struct packed {
        cad_fsm_e    fsm;
        logic [15:0] pc;
        logic [7:0]  x;
        logic [7:0]  y;
        logic [1:0]  argc;
        logic [1:0]  argi;
        logic        btj;
        logic        ptrw;
        logic [7:0]  arg0;
        logic [7:0]  arg1;
        logic [7:0]  ptr_hi;
        logic [15:0] mem_addr;
        logic        mem_rd;
        logic        done;
        logic        busy;
        cad_res_s    res;
    } cad_st_s;

endpackage : cad_pkg

// File: test/cad_decoder_assertions.sv
`timescale 1ns/100ps
module cad_decoder_checker
    import cad_pkg::*;
(
    input wire logic        sys_clk_in,   // Clock
    input wire logic        rst_b_in,     // Reset
    input wire logic        start_in,     // Start
    input wire logic [15:0] pc_in,        // Address
    input wire logic [7:0]  x_in,         // Index one
    input wire logic [7:0]  y_in,         // Index two
    input wire logic [7:0]  mem_rdata_in, // Read data
    input wire logic        mem_ack_in,   // Read done
    input wire logic [15:0] mem_addr_out, // Read address
    input wire logic        mem_rd_out,   // Read request
    input wire logic        busy_out,     // Busy
    input wire logic        done_out,     // Result strobe
    input wire cad_res_s    res_out       // Result
);
    logic [15:0] pc_ff;
    logic [7:0]  x_ff;
    logic [7:0]  y_ff;
    logic [15:0] nxt_pc;
    logic [15:0] rel_d;
    logic [2:0]  pl;
    logic        ok;
    cad_mode_e   m;
    assign ok     = done_out && !res_out.illegal;
    assign m      = res_out.mode;
    assign pl     = (res_out.prebyte == NO_PREBYTE) ? 3'h0 : 3'h1;
    assign nxt_pc = pc_ff + 16'(res_out.len);
    assign rel_d  = res_out.target - nxt_pc;
    // Inputs are only sampled at a taken start, so keep our own copy
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            pc_ff <= 16'h0000;
            x_ff  <= 8'h00;
            y_ff  <= 8'h00;
        end else if (start_in && !busy_out) begin
            pc_ff <= pc_in;
            x_ff  <= x_in;
            y_ff  <= y_in;
        end
    end
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_inh_len: assert property (ok && m == AM_INH |-> res_out.len == pl + 3'h1)
        else $error("inherent length wrong");
    a_dir_page: assert property (ok && m == AM_DIR_S |-> res_out.ea[15:8] == 8'h00)
        else $error("short direct left page zero");
    a_idx0_ea: assert property (ok && m == AM_IDX0 |-> res_out.len == pl + 3'h1
        && res_out.ea == {8'h00, (res_out.iy ? y_ff : x_ff)}) else $error("no-offset ea wrong");
    a_idxs_range: assert property (ok && m inside {AM_IDX_S, AM_IIDX_S}
        |-> res_out.ea <= 16'h01fe) else $error("short indexed ea out of range");
    a_ind_len: assert property (ok && m inside {AM_IND_S, AM_IND_L, AM_IIDX_S,
        AM_IIDX_L, AM_REL_I} |-> res_out.len == 3'h3 + 3'(res_out.opcode == {GRP_DIRS, OP_BIT_JUMP}))
        else $error("indirect length wrong");
    a_long_class: assert property (ok && m inside {AM_DIR_L, AM_IDX_L, AM_IND_L,
        AM_IIDX_L} |-> res_out.opcode[3:0] <= OP_LAST_LONG) else $error("long form bad class");
    a_pre91_iy: assert property (done_out && res_out.prebyte == 8'h91 |-> res_out.illegal
        || (res_out.iy && m inside {AM_IIDX_S, AM_IIDX_L})) else $error("91 prebyte misused");
    a_rel_range: assert property (ok && m inside {AM_REL_D, AM_REL_I}
        |-> rel_d <= 16'h007f || rel_d >= 16'hff80) else $error("relative target out of reach");
    a_next_pc: assert property (ok && !(m inside {AM_REL_D, AM_REL_I})
        && res_out.opcode[3:0] != OP_BIT_JUMP |-> res_out.target == nxt_pc)
        else $error("next address wrong");
    a_rd_hold: assert property (mem_rd_out && !mem_ack_in |=> mem_rd_out
        && $stable(mem_addr_out)) else $error("read dropped before ack");
    a_start_done: assert property (start_in && !busy_out |-> ##[1:80] done_out)
        else $error("decode did not finish");
    c_illegal: cover property (done_out && res_out.illegal);
    c_iidx_l: cover property (ok && m == AM_IIDX_L);
    c_rel_i: cover property (ok && m == AM_REL_I);
endmodule : cad_decoder_checker

bind cad_decoder cad_decoder_checker cad_decoder_checker_i (.sys_clk_in, .rst_b_in, .start_in,
    .pc_in, .x_in, .y_in, .mem_rdata_in, .mem_ack_in, .mem_addr_out, .mem_rd_out, .busy_out,
    .done_out, .res_out);

// File: test/cad_decoder_tb.sv
`timescale 1ns/100ps
module cad_decoder_tb
    import cad_pkg::*;
;
    logic        sys_clk_in, rst_b_in, start_in, mem_ack_in, mem_rd_out, busy_out, done_out;
    logic [15:0] pc_in, mem_addr_out, pc;
    logic [7:0]  x_in, y_in, mem_rdata_in;
    logic [1:0]  lat;
    logic [31:0] pres = 32'h00909192;
    cad_res_s    res_out;
    int          mismatches, n_tests, i;
    // pre, opcode, arg0, arg1, x
    logic [39:0] corner [16] = '{40'h0050ff00ff, 40'h9251ff00ff, 40'h9230ff0000, 40'h007f800000,
        40'h007e7f0000, 40'h9270ff0000, 40'h9240000000, 40'h9090000000, 40'h0035000000,
        40'h0064ffff02, 40'h002b100500, 40'h922b100500, 40'h9162200000, 40'h9040000000,
        40'h9120000000, 40'h9070000000};

    always #25 sys_clk_in = ~sys_clk_in;

    cad_decoder cad_decoder_i (.sys_clk_in, .rst_b_in, .start_in, .pc_in, .x_in, .y_in,
        .mem_rdata_in, .mem_ack_in, .mem_addr_out, .mem_rd_out, .busy_out, .done_out, .res_out);
    cad_mem_model cad_mem_model_i (.sys_clk_in, .rst_b_in, .lat_in(lat),
        .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out), .mem_rdata_out(mem_rdata_in),
        .mem_ack_out(mem_ack_in));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (exp !== got) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] rd(logic [15:0] a);
        return cad_mem_model_i.mem[a];
    endfunction : rd

    function automatic cad_res_s expect_res(logic [15:0] pc, logic [7:0] x, logic [7:0] y);
        cad_res_s    e;
        logic [15:0] a, p, w;
        logic [7:0]  pre, op, a0, idx;
        logic [3:0]  g;
        logic [2:0]  n;
        logic        ind;
        e = RES_RST;
        pre = rd(pc);
        if (!(pre inside {8'h90, 8'h91, 8'h92})) pre = NO_PREBYTE;
        a = pc + ((pre == NO_PREBYTE) ? 16'h0 : 16'h1);
        op = rd(a);
        g = op[7:4];
        a0 = rd(a + 16'h1);
        w = {a0, rd(a + 16'h2)};
        p = {rd({8'h00, a0}), rd({8'h00, a0} + 16'h1)};
        ind = pre inside {8'h91, 8'h92};
        e.opcode = op;
        e.prebyte = pre;
        e.iy = pre inside {8'h90, 8'h91};
        idx = e.iy ? y : x;
        n = (pre == NO_PREBYTE) ? 3'h1 : 3'h2;
        e.len = n;
        e.illegal = g > 4'h7 || (g inside {4'h3, 4'h6} && op[3:0] > OP_LAST_LONG)
            || (pre == 8'h90 && g == 4'h7) || (pre == 8'h92 && !(g inside {2, 3, 5, 6, 7}))
            || (pre == 8'h91 && !(g inside {5, 6}));
        if (e.illegal) return e;
        case (g)
            4'h0: e.mode = AM_INH;
            4'h1: begin e.mode = AM_IMM; e.imm = a0; e.ea = {8'h00, a0}; n += 3'h1; end
            4'h2: begin e.mode = ind ? AM_IND_S : AM_DIR_S; e.ea = ind ? {8'h00, p[15:8]}
                : {8'h00, a0}; n += (op[3:0] == OP_BIT_JUMP) ? 3'h2 : 3'h1; end
            4'h3: begin e.mode = ind ? AM_IND_L : AM_DIR_L; e.ea = ind ? p : w;
                n += ind ? 3'h1 : 3'h2; end
            4'h4: begin e.mode = AM_IDX0; e.ea = {8'h00, idx}; end
            4'h5: begin e.mode = ind ? AM_IIDX_S : AM_IDX_S; n += 3'h1;
                e.ea = (ind ? {8'h00, p[15:8]} : {8'h00, a0}) + {8'h00, idx}; end
            4'h6: begin e.mode = ind ? AM_IIDX_L : AM_IDX_L; n += ind ? 3'h1 : 3'h2;
                e.ea = (ind ? p : w) + {8'h00, idx}; end
            default: begin e.mode = ind ? AM_REL_I : AM_REL_D; n += 3'h1;
                e.ea = ind ? 16'h0000 : {8'h00, a0}; a0 = ind ? p[15:8] : a0; end
        endcase
        e.len = n;
        e.target = pc + 16'(n) + ((g == 4'h7) ? {{8{a0[7]}}, a0} : 16'h0000);
        return e;
    endfunction : expect_res

    task automatic put(logic [15:0] at, logic [7:0] pre, logic [7:0] op, logic [7:0] a0,
        logic [7:0] a1);
        if (pre == 8'h90 && op == 8'h2b) op = 8'h2a;
        if (pre != NO_PREBYTE) cad_mem_model_i.mem[at] = pre;
        at = at + ((pre == NO_PREBYTE) ? 16'h0 : 16'h1);
        cad_mem_model_i.mem[at] = op;
        cad_mem_model_i.mem[at + 16'h1] = a0;
        cad_mem_model_i.mem[at + 16'h2] = a1;
    endtask : put

    task automatic run_one(logic [15:0] at, logic [7:0] x, logic [7:0] y);
        cad_res_s e;
        int       k;
        e = expect_res(at, x, y);
        @(posedge sys_clk_in);
        start_in <= 1'b1;
        pc_in <= at;
        x_in <= x;
        y_in <= y;
        lat <= 2'($urandom);
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        for (k = 0; k < 100 && done_out !== 1'b1; k++) @(posedge sys_clk_in);
        if (k == 100) begin
            mismatches++;
            $display("mismatch done expected 1 seen 0");
            stop_test();
        end
        check("illegal", e.illegal, res_out.illegal);
        check("opcode", e.opcode, res_out.opcode);
        check("prebyte", e.prebyte, res_out.prebyte);
        check("len", e.len, res_out.len);
        if (e.illegal || e.mode != AM_INH) check("ea", e.ea, res_out.ea);
        if (e.opcode != 8'h2b) check("target", e.target, res_out.target);
        if (e.illegal) return;
        check("mode", e.mode, res_out.mode);
        check("iy", e.iy, res_out.iy);
        if (e.mode == AM_IMM) check("imm", e.imm, res_out.imm);
    endtask : run_one

    initial begin
        sys_clk_in = 1'b0;
        rst_b_in = 1'b0;
        start_in = 1'b0;
        pc_in = 16'h0000;
        x_in = 8'h00;
        y_in = 8'h00;
        lat = 2'h0;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(32'h87c0924d));
        for (i = 0; i < 65536; i++) cad_mem_model_i.mem[i] = 8'($urandom);
        cad_mem_model_i.mem[16'h00ff] = 8'hff;
        repeat (6) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        for (i = 0; i < 16; i++) begin
            pc = 16'h0400 + 16'(i * 8);
            put(pc, corner[i][39:32], corner[i][31:24], corner[i][23:16], corner[i][15:8]);
            run_one(pc, corner[i][7:0], 8'h5a);
        end
        $display("boundary cases done");
        for (i = 0; i < 32; i++) begin
            pc = 16'h0800 + 16'(i * 8);
            put(pc, pres[8 * (i % 4) +: 8], {4'(i / 4), 4'($urandom)}, 8'($urandom), 8'($urandom));
            run_one(pc, 8'($urandom), 8'($urandom));
        end
        $display("mode sweep done");
        for (i = 0; i < 300; i++) begin
            pc = 16'($urandom_range(32'h0200, 32'hfff0));
            put(pc, pres[8 * $urandom_range(0, 3) +: 8], 8'($urandom), 8'($urandom), 8'($urandom));
            run_one(pc, 8'($urandom), 8'($urandom));
        end
        $display("random instructions done");
        stop_test();
    end
endmodule : cad_decoder_tb

// File: test/cad_mem_model.sv
`timescale 1ns/100ps
module cad_mem_model
    import cad_pkg::*;
(
    input  wire logic        sys_clk_in,    // Core clock
    input  wire logic        rst_b_in,      // Reset, active low
    input  wire logic [1:0]  lat_in,        // Wait cycles before ack
    input  wire logic [15:0] mem_addr_in,   // Read address
    input  wire logic        mem_rd_in,     // Read request
    output logic      [7:0]  mem_rdata_out, // Read data
    output logic             mem_ack_out    // Read done
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_ff;
    logic       gap_ff;

    // Dead cycle after each ack
    assign mem_ack_out   = mem_rd_in && !gap_ff && (wait_ff >= lat_in);
    // Outside an ack the lines show the inverse of the real byte
    assign mem_rdata_out = mem_ack_out ? mem[mem_addr_in] : ~mem[mem_addr_in];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            wait_ff <= 2'h0;
            gap_ff  <= 1'b0;
        end else begin
            gap_ff <= mem_ack_out;
            if (mem_ack_out || !mem_rd_in) begin
                wait_ff <= 2'h0;
            end else begin
                wait_ff <= wait_ff + 2'h1;
            end
        end
    end
endmodule : cad_mem_model
